// [rtl/atacbd_decoder.sv]
`timescale 1ns/10ps
`include "atacbd_regs.svh"
module atacbd_decoder (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [127:0] ata_passthrough_block,
  output atacbd_pkg::atacbd_tf_req_type tf_req,
  input wire logic tf_ack,
  input wire logic [7:0] tf_rdata,
  output logic [63:0] readback_bytes,
  output atacbd_pkg::atacbd_result_type result,
  output logic done,
  output logic busy,
  output logic reserved_nonzero
);
  // Reset synchroniser stages
  logic rst_s1_q, rst_s1_d;
  logic rst_s2_q, rst_s2_d;
  // Sequencer state and the block fields kept for the run
  atacbd_pkg::atacbd_state_type state_q, state_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] taskfile_select_mask_q, taskfile_select_mask_d;
  logic [63:0] taskfile_write_bytes_q, taskfile_write_bytes_d;
  logic [63:0] rb_q, rb_d;
  logic rdonly_q, rdonly_d;
  atacbd_pkg::atacbd_result_type res_q, res_d;
  logic rsvd_q, rsvd_d;
  // Registered request toward the drive side
  atacbd_pkg::atacbd_tf_req_type req_q, req_d;
  // Count decode and raw fields of the incoming block
  logic count_legal;
  logic [8:0] count_sectors;
  logic [7:0] action_control_byte;
  logic [7:0] sectors_per_block_byte;

  // Byte n of the block sits at bits [8n+7:8n]
  function automatic logic [7:0] blk_byte(input logic [127:0] blk, input logic [3:0] n);
    blk_byte = blk[{n, 3'h0} +: 8];
  endfunction

  // Taskfile address for a select-bit position
  function automatic logic [9:0] tf_addr(input logic [2:0] i);
    tf_addr = (i == 3'h0) ? `ATACBD_ADDR_CTL : (`ATACBD_ADDR_BASE + {7'h00, i});
  endfunction

  // Lowest selected bit at or above a position
  function automatic logic [3:0] next_sel(input logic [7:0] m, input logic [3:0] from);
    next_sel = 4'h8;
    for (int k = 7; k >= 0; k--) begin
      if (m[k] && (4'(k) >= from)) begin
        next_sel = 4'(k);
      end
    end
  endfunction

  // Layout guards: an edited header must keep the count, write and reserved byte fields back to back
  if (`ATACBD_OFS_WDATA + `ATACBD_RB_BYTES != `ATACBD_OFS_RSVD) begin : g_layout_check
    $error("Write bytes and reserved bytes overlap");
  end
  if (`ATACBD_OFS_COUNT + 4'h1 != `ATACBD_OFS_WDATA) begin : g_count_check
    $error("Count byte does not precede the write bytes");
  end

  // Synchroniser next values; only the second stage feeds the rest of the block
  always_comb begin
    rst_s1_d = 1'b1;
    rst_s2_d = rst_s1_q;
  end

  // Reset released through two flops to avoid release metastability
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= rst_s1_d;
      rst_s2_q <= rst_s2_d;
    end
  end

  // Raw fields, meaningful only while start is high
  assign action_control_byte = blk_byte(ata_passthrough_block, `ATACBD_OFS_ACTION);
  assign sectors_per_block_byte = blk_byte(ata_passthrough_block, `ATACBD_OFS_COUNT);

  atacbd_count_check u_count (
    .count_byte(sectors_per_block_byte),
    .legal(count_legal),
    .sectors(count_sectors)
  );

  // Sequencer next state
  always_comb begin
    logic [3:0] nxt;
    nxt = 4'h8;
    // Hold every value unless a branch below moves it
    state_d = state_q;
    idx_d = idx_q;
    taskfile_select_mask_d = taskfile_select_mask_q;
    taskfile_write_bytes_d = taskfile_write_bytes_q;
    rb_d = rb_q;
    rdonly_d = rdonly_q;
    res_d = res_q;
    rsvd_d = rsvd_q;
    case (state_q)
      // Block taken only here; a start while busy is ignored
      atacbd_pkg::ATACBD_IDLE: begin
        if (start) begin
          taskfile_select_mask_d = blk_byte(ata_passthrough_block, `ATACBD_OFS_SELECT);
          taskfile_write_bytes_d = ata_passthrough_block[`ATACBD_OFS_WDATA*8 +: 64];
          rdonly_d = action_control_byte[`ATACBD_BIT_READBACK];
          rsvd_d = |ata_passthrough_block[127:`ATACBD_OFS_RSVD*8];
          rb_d = 64'h0;
          res_d.sectors = count_sectors;
          res_d.readback_only = action_control_byte[`ATACBD_BIT_READBACK];
          res_d.ok = 1'b0;
          res_d.fail = 1'b0;
          // First selected register, or 8 when the mask is empty
          nxt = next_sel(blk_byte(ata_passthrough_block, `ATACBD_OFS_SELECT), 4'h0);
          // Readback never transfers data, so the count is not checked then
          if (!count_legal && !action_control_byte[`ATACBD_BIT_READBACK]) begin
            res_d.fail = 1'b1;
            state_d = atacbd_pkg::ATACBD_DONE;
          end else if (nxt[3]) begin
            res_d.ok = 1'b1;
            state_d = atacbd_pkg::ATACBD_DONE;
          end else begin
            idx_d = nxt[2:0];
            state_d = atacbd_pkg::ATACBD_RUN;
          end
        end
      end
      // Advance on each acknowledge
      atacbd_pkg::ATACBD_RUN: begin
        if (tf_ack) begin
          if (rdonly_q) begin
            rb_d[{idx_q, 3'h0} +: 8] = tf_rdata;
          end
          // Next selected register above the one just served
          nxt = next_sel(taskfile_select_mask_q, {1'b0, idx_q} + 4'h1);
          if (nxt[3]) begin
            res_d.ok = 1'b1;
            state_d = atacbd_pkg::ATACBD_DONE;
          end else begin
            idx_d = nxt[2:0];
          end
        end
      end
      // Result strobe lasts one cycle
      atacbd_pkg::ATACBD_DONE: begin
        state_d = atacbd_pkg::ATACBD_IDLE;
      end
      default: begin
        state_d = atacbd_pkg::ATACBD_IDLE;
      end
    endcase
  end

  // State registers, frozen while clock enable is low
  always_ff @(posedge clock or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      state_q <= atacbd_pkg::ATACBD_IDLE;
      idx_q <= 3'h0;
      taskfile_select_mask_q <= 8'h00;
      taskfile_write_bytes_q <= 64'h0;
      rb_q <= 64'h0;
      rdonly_q <= 1'b0;
      res_q <= '0;
      rsvd_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      idx_q <= idx_d;
      taskfile_select_mask_q <= taskfile_select_mask_d;
      taskfile_write_bytes_q <= taskfile_write_bytes_d;
      rb_q <= rb_d;
      rdonly_q <= rdonly_d;
      res_q <= res_d;
      rsvd_q <= rsvd_d;
    end
  end

  // Request built from next values so the flopped copy lines up with the state
  always_comb begin
    req_d.valid = (state_d == atacbd_pkg::ATACBD_RUN);
    req_d.write = !rdonly_d;
    req_d.addr = tf_addr(idx_d);
    req_d.data = rdonly_d ? 8'h00 : taskfile_write_bytes_d[{idx_d, 3'h0} +: 8];
    req_d.index = idx_d;
  end

  // Request held until acknowledged; only selected bytes ever reach the bus
  always_ff @(posedge clock or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      req_q.valid <= 1'b0;
      req_q.write <= 1'b1;
      req_q.addr <= `ATACBD_ADDR_CTL;
      req_q.data <= 8'h00;
      req_q.index <= 3'h0;
    end else if (clk_en) begin
      req_q <= req_d;
    end
  end

  // Data outputs come from flops; done and busy are decoded from the state
  assign tf_req = req_q;
  assign readback_bytes = rb_q;
  assign result = res_q;
  assign done = (state_q == atacbd_pkg::ATACBD_DONE);
  assign busy = (state_q != atacbd_pkg::ATACBD_IDLE);
  assign reserved_nonzero = rsvd_q;
endmodule

// [shared/atacbd_regs.svh]
`ifndef ATACBD_REGS_SVH
`define ATACBD_REGS_SVH
// Byte positions inside the 16-byte pass-through block
`define ATACBD_OFS_ACTION 4'h2
`define ATACBD_OFS_SELECT 4'h3
`define ATACBD_OFS_COUNT 4'h4
`define ATACBD_OFS_WDATA 4'h5
`define ATACBD_OFS_RSVD 4'hD
// Action byte field position
`define ATACBD_BIT_READBACK 0
// Sector size in bytes
`define ATACBD_SECTOR_BYTES 16'h0200
// Count value 0 stands for this many sectors
`define ATACBD_ZERO_SECTORS 9'h100
// Taskfile port addresses in select-bit order
`define ATACBD_ADDR_CTL 10'h3F6
`define ATACBD_ADDR_BASE 10'h1F0
`define ATACBD_RB_BYTES 4'h8
`endif

// [shared/atacbd_pkg.sv]
package atacbd_pkg;
  typedef enum logic [1:0] {
    ATACBD_IDLE = 2'h0,
    ATACBD_RUN = 2'h1,
    ATACBD_DONE = 2'h3
  } atacbd_state_type;

  // One taskfile access request toward the drive side
  typedef struct packed {
    logic valid;
    logic write;
    logic [9:0] addr;
    logic [7:0] data;
    logic [2:0] index;
  } atacbd_tf_req_type;

  // Decode result of one block
  typedef struct packed {
    logic ok;
    logic fail;
    logic readback_only;
    logic [8:0] sectors;
  } atacbd_result_type;
endpackage

// [rtl/atacbd_count_check.sv]
`timescale 1ns/10ps
`include "atacbd_regs.svh"
module atacbd_count_check (
  input wire logic [7:0] count_byte,
  output logic legal,
  output logic [8:0] sectors
);
  // Legal set is zero or a single set bit
  always_comb begin
    legal = (count_byte == 8'h00) || ((count_byte & (count_byte - 8'h01)) == 8'h00);
    sectors = (count_byte == 8'h00) ? `ATACBD_ZERO_SECTORS : {1'b0, count_byte};
  end
endmodule

// [dv/atacbd_sva.sv]
`timescale 1ns/10ps
module atacbd_sva (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [127:0] ata_passthrough_block,
  input atacbd_pkg::atacbd_tf_req_type tf_req,
  input wire logic tf_ack,
  input wire logic [7:0] tf_rdata,
  input wire logic [63:0] readback_bytes,
  input atacbd_pkg::atacbd_result_type result,
  input wire logic done,
  input wire logic busy,
  input wire logic reserved_nonzero
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire [127:0] b = ata_passthrough_block;
  // Readback skips the count check, so either makes a run
  wire go = b[16] || $onehot0(b[39:32]);
  sequence s_take(c);
    clk_en && start && !busy && c;
  endsequence
  sequence s_step;
    tf_req.valid && tf_ack && clk_en ##1 tf_req.valid;
  endsequence
  a_fail_illegal: assert property (s_take(!b[16] && !$onehot0(b[39:32])) |=> done && result.fail)
    else $error("bad count not failed");
  a_count_pass: assert property (s_take(!b[16] && $onehot0(b[39:32]) && b[31:24] == 8'h00) |=>
    done && result.ok && result.sectors == ($past(b[39:32]) == 8'h00 ? 9'h100 : {1'b0, $past(b[39:32])}))
    else $error("count result wrong");
  a_first_req: assert property (s_take(go && b[24]) |=> tf_req.valid && tf_req.index == 3'h0)
    else $error("first access wrong");
  a_wdata_map: assert property (s_take(!b[16] && go && b[24]) |=> tf_req.write && tf_req.data == $past(b[47:40]))
    else $error("write byte wrong");
  a_req_hold: assert property (tf_req.valid && !tf_ack && clk_en |=> $stable(tf_req))
    else $error("request moved");
  a_addr_map: assert property (tf_req.valid |-> tf_req.addr == (tf_req.index == 3'h0 ? 10'h3F6 : 10'h1F0 + tf_req.index))
    else $error("address wrong");
  a_ascending_order: assert property (s_step |-> tf_req.index > $past(tf_req.index))
    else $error("order wrong");
  a_enable_freeze: assert property (!clk_en |=> $stable(tf_req) && $stable(result) && $stable(busy))
    else $error("state moved while disabled");
  a_read_only: assert property (s_take(b[16] && b[31:24] != 8'h00) |=> tf_req.valid && !tf_req.write)
    else $error("write in readback");
endmodule
bind atacbd_decoder atacbd_sva u_sva (.*);

// [dv/atacbd_drive_model.sv]
`timescale 1ns/10ps
module atacbd_drive_model (
  input wire logic clock,
  input atacbd_pkg::atacbd_tf_req_type tf_req,
  input wire logic [3:0] slow,
  output logic tf_ack = 1'b0,
  output logic [7:0] tf_rdata
);
  logic [3:0] cnt_q = 4'h0;
  // Ack after slow waits; slow 0 leaves ack up for back-to-back
  always @(negedge clock) begin
    if (!tf_req.valid || (tf_ack && slow != 4'h0)) begin
      tf_ack <= 1'b0;
      cnt_q <= 4'h0;
    end else if (cnt_q >= slow) tf_ack <= 1'b1;
    else cnt_q <= cnt_q + 4'h1;
  end
  // Data is meaningless without ack, so it flips then
  assign tf_rdata = tf_ack ? ~tf_req.addr[7:0] : tf_req.addr[7:0];
endmodule

// [dv/ata_command_block_decoder_tb_top.sv]
`timescale 1ns/10ps
module ata_command_block_decoder_tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [127:0] blk = 128'h0;
  logic [3:0] slow = 4'h0;
  logic en = 1'b1;
  logic rsvd;
  logic tf_ack, done, busy;
  logic [7:0] tf_rdata;
  logic [63:0] rb;
  atacbd_pkg::atacbd_tf_req_type req;
  atacbd_pkg::atacbd_result_type res;
  logic [18:0] log[$];
  int n_errors = 0;
  int n_checks = 0;
  always #5 clock = ~clock;
  atacbd_decoder DUT (.clock(clock), .rst_n(rst_n), .clk_en(en), .start(start), .ata_passthrough_block(blk),
    .tf_req(req), .tf_ack(tf_ack), .tf_rdata(tf_rdata), .readback_bytes(rb), .result(res), .done(done),
    .busy(busy), .reserved_nonzero(rsvd));
  atacbd_drive_model u_drv (.clock(clock), .tf_req(req), .slow(slow), .tf_ack(tf_ack), .tf_rdata(tf_rdata));
  // Every accepted access, in order
  always @(posedge clock) if (req.valid && tf_ack && en) log.push_back({req.write, req.addr, req.data});
  function automatic logic [9:0] ad(int k);
    return k == 0 ? 10'h3F6 : 10'h1F0 + 10'(k);
  endfunction
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Bounded wait for the result strobe
  task automatic wait_done;
    int i;
    for (i = 0; i < 99 && done !== 1'b1; i++) @(negedge clock);
    if (done !== 1'b1) begin
      n_errors++;
      end_of_test();
    end
  endtask
  // One block; bytes 13-15 left zero
  task automatic run(logic [7:0] act, logic [7:0] mask, logic [7:0] cnt);
    logic [127:0] b;
    b = {24'h0, 64'h37363534_33323130, cnt, mask, act, 16'h0};
    log.delete();
    @(negedge clock);
    blk = b;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    wait_done();
  endtask
  task automatic t_write(logic [7:0] mask, logic [7:0] cnt, logic [3:0] s);
    int k;
    int j;
    slow = s;
    j = 0;
    run(8'h00, mask, cnt);
    for (k = 0; k < 8; k++) if (mask[k]) begin
      chk("access", {1'b1, ad(k), 8'h30 + 8'(k)}, log.size() > j ? log[j] : 19'h0);
      j++;
    end
    chk("accesses", j, log.size());
    chk("result", {3'b100, cnt == 8'h00 ? 9'h100 : {1'b0, cnt}}, res);
    chk("reserved", 1'b0, rsvd);
  endtask
  // Called twice so stale bytes of the first readback must be cleared
  task automatic t_readback(logic [7:0] mask);
    logic [63:0] e;
    int k;
    e = 64'h0;
    slow = 4'h1;
    run(8'h01, mask, 8'h03);
    for (k = 0; k < 8; k++) if (mask[k]) e[8 * k +: 8] = ~8'(ad(k));
    chk("readback", e, rb);
    chk("status", 3'b101, res[11:9]);
    chk("reads", $countones(mask), log.size());
    foreach (log[i]) chk("read", 1'b0, log[i][18]);
  endtask
  // Clock enable dropped mid-run must freeze request and sequencer
  task automatic t_freeze;
    atacbd_pkg::atacbd_tf_req_type hold;
    int k;
    slow = 4'h0;
    log.delete();
    @(negedge clock);
    blk = {24'h0, 64'h37363534_33323130, 8'h01, 8'hFF, 8'h00, 16'h0};
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    en = 1'b0;
    hold = req;
    repeat (5) @(negedge clock);
    chk("frozen req", hold, req);
    chk("frozen busy", 1'b1, busy);
    chk("frozen log", 0, log.size());
    en = 1'b1;
    wait_done();
    for (k = 0; k < 8; k++) begin
      chk("access", {1'b1, ad(k), 8'h30 + 8'(k)}, log.size() > k ? log[k] : 19'h0);
    end
    chk("result", {3'b100, 9'h001}, res);
  endtask
  // Every count value with an empty mask
  task automatic t_counts;
    int c;
    logic lg;
    for (c = 0; c < 256; c++) begin
      lg = (c & (c - 1)) == 0;
      run(8'h00, 8'h00, 8'(c));
      chk("status", {lg, !lg, 1'b0}, res[11:9]);
      if (lg) chk("sectors", c == 0 ? 256 : c, res.sectors);
    end
  endtask
  initial begin
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    t_write(8'hA5, 8'h10, 4'h2);
    t_write(8'hFF, 8'h00, 4'h0);
    t_readback(8'h7C);
    t_readback(8'h83);
    t_freeze();
    t_counts();
    end_of_test();
  end
endmodule
